/* File: pkg/gpm_pkg.sv */
// Shared constants for the general purpose pin port
package gpm_pkg;

   // Width of the pin vector; positions 4 to 6 are not bonded out
   localparam int unsigned PIN_W = 10;
   // Bonded pins: 0, 1, 2, 3, 7, 8, 9
   localparam logic [9:0] PIN_MASK = 10'h38f;

   // Pin positions that carry an alternate function
   localparam int unsigned PIN_PORT_TWO_RST = 0;
   localparam int unsigned PIN_EXP_INT = 2;
   localparam int unsigned PIN_EVENT = 7;
   localparam int unsigned PIN_PORT_ONE_RST = 8;
   localparam int unsigned PIN_PORT_THREE_RST = 9;

   // Reset values: general input, nothing driven
   localparam logic [9:0] FUNC_RESET = 10'h000;
   localparam logic [9:0] DIR_RESET = 10'h000;
   localparam logic [9:0] DRIVE_RESET = 10'h000;
   localparam logic [9:0] LEVEL_RESET = 10'h000;

   // Direction and function encodings
   localparam logic FUNC_GPIO = 1'b0;
   localparam logic FUNC_ALT = 1'b1;
   localparam logic DIR_IN = 1'b0;
   localparam logic DIR_OUT = 1'b1;

   // Inactive level of the active-low alternate signals
   localparam logic ALT_INACTIVE = 1'b1;

   // Sampling interval of general inputs, least time
   localparam int unsigned SAMPLE_NS = 128;
   localparam int unsigned CLK_NS = 40;
   localparam int unsigned SAMPLE_CYC_RAW = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned SAMPLE_CYC =
      (SAMPLE_CYC_RAW < 1) ? 1 : SAMPLE_CYC_RAW;
   localparam int unsigned SAMPLE_CNT_W = 3;
   localparam logic [2:0] SAMPLE_LAST = 3'(SAMPLE_CYC - 1);
   localparam logic [2:0] SAMPLE_CNT_RESET = 3'h0;

endpackage

/* File: core/gpm_sync.sv */
`timescale 1ns/100ps

// Two-stage synchroniser, one chain per bit
module gpm_sync #(
   parameter int unsigned WIDTH = 10,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end

endmodule // gpm_sync

/* File: core/gpm_port.sv */
`timescale 1ns/100ps

// Notes on behaviour
// - Seven pins exist; each can be a general input or output, pins 0, 2, 7, 8, 9 also an alternate.
// - Each pin owns one bit in the function, direction and data registers.
// - Function bit 1 picks the alternate, else direction 0 input, 1 output.
// - Pins 0, 8 and 9 in alternate mode drive resets of ports 2, 1 and 3.
// - Pin 2 in alternate mode carries the expander interrupt inward.
// - Pin 7 in alternate mode drives the general purpose event output.
// - After reset every pin is a general input, alternates off, not driven.
// - General inputs are sampled no faster than every 128 ns, async-safe.
// - Pin 2 in general use holds the expander interrupt input at the inactive level.
// - A general input pin level is registered into its data bit.
// - The data register always reads back each pin's actual level.
// - A general output pin drives the value held in its data bit.
module gpm_port #(
   parameter int unsigned PIN_W = gpm_pkg::PIN_W,
   parameter logic [9:0] PIN_MASK = gpm_pkg::PIN_MASK
) (
   input wire logic clk,
   input wire logic arst_n,
   // Configuration writes from the upstream port's config space
   input wire logic func_wr,
   input wire logic [9:0] func_wdata,
   input wire logic dir_wr,
   input wire logic [9:0] dir_wdata,
   input wire logic data_wr,
   input wire logic [9:0] data_wdata,
   // Read-back views
   output logic [9:0] pin_function_select,
   output logic [9:0] pin_direction_config,
   output logic [9:0] pin_data_value,
   // On-chip alternate sources, active low
   input wire logic downstream_port_two_reset_out_n,
   input wire logic downstream_port_one_reset_out_n,
   input wire logic downstream_port_three_reset_out_n,
   input wire logic event_output_n,
   // Alternate input towards on-chip logic, active low
   output logic expander_interrupt_in_n,
   // Pins
   input wire logic [9:0] pin_in,
   output logic [9:0] pin_out,
   output logic [9:0] pin_oe
);

   // Stored configuration and drive values; bits 4 to 6 never hold a
   // one because every write is masked to the bonded pins
   logic [9:0] func_sel;
   logic [9:0] dir_cfg;
   logic [9:0] drive_val;
   logic [9:0] level;
   logic [9:0] pin_sync;
   logic [2:0] sample_cnt;
   logic [9:0] next_pin_out;
   logic [9:0] next_pin_oe;
   logic next_exp_int_n;

   // Decoded per-pin modes; the three exclude each other on every
   // bonded pin, and unbonded positions fall in none of them
   wire logic [9:0] alt_mode = func_sel & PIN_MASK;
   wire logic [9:0] gp_out_mode = ~func_sel & dir_cfg & PIN_MASK;
   wire logic [9:0] gp_in_mode = ~func_sel & ~dir_cfg & PIN_MASK;
   wire logic sample_tick = (sample_cnt == gpm_pkg::SAMPLE_LAST);

   // Alternate output sources laid onto their pin positions
   // Sources pass straight through, still active low, no inversion
   wire logic [9:0] alt_src = {
      downstream_port_three_reset_out_n,
      downstream_port_one_reset_out_n,
      event_output_n,
      6'h00, // Pins 6 to 1 carry no output alternate
      downstream_port_two_reset_out_n
   };
   // Pins whose alternate function is an output
   // Pin 2 is missing here: its alternate is an input, never driven
   wire logic [9:0] alt_out_pins = (10'h1 << gpm_pkg::PIN_PORT_TWO_RST)
      | (10'h1 << gpm_pkg::PIN_EVENT)
      | (10'h1 << gpm_pkg::PIN_PORT_ONE_RST)
      | (10'h1 << gpm_pkg::PIN_PORT_THREE_RST);

   // Pin drive: alternate source, stored value, or released
   // A general input or pin 2 in alternate mode leaves the enable low, so the
   // board may drive those pins without contention
   assign next_pin_oe = (alt_mode & alt_out_pins) | gp_out_mode;
   assign next_pin_out = (alt_mode & alt_out_pins & alt_src)
      | (gp_out_mode & drive_val);

   // Expander interrupt passes only in alternate mode, else held idle
   // Held high while the pin is general, so no false request leaks in
   assign next_exp_int_n = alt_mode[gpm_pkg::PIN_EXP_INT]
      ? pin_sync[gpm_pkg::PIN_EXP_INT]
      : gpm_pkg::ALT_INACTIVE;

   // Pins are asynchronous to the core clock, two flops first
   // Every pin goes through the chain, outputs too, so the read-back
   // shows the level on the wire rather than the level meant for it
   gpm_sync #(
      .WIDTH(10),
      .RESET_VAL(gpm_pkg::LEVEL_RESET)
   ) u_pin_sync (
      .clk(clk),
      .arst_n(arst_n),
      .async_in(pin_in),
      .sync_out(pin_sync)
   );

   // Sampling interval counter; the pace keeps input glitches rarer to see
   // Free-running from reset; the least interval is rounded up to
   // whole clock periods, so sampling is never faster than allowed
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sample_cnt <= gpm_pkg::SAMPLE_CNT_RESET;
      end else if (sample_tick) begin
         sample_cnt <= gpm_pkg::SAMPLE_CNT_RESET;
      end else begin
         sample_cnt <= sample_cnt + 3'h1;
      end
   end

   // Function select register, one bit per pin
   // Writes to unbonded positions are dropped here, not at read-back
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         func_sel <= gpm_pkg::FUNC_RESET;
      end else if (func_wr) begin
         func_sel <= func_wdata & PIN_MASK;
      end
   end

   // Direction register, one bit per pin
   // Ignored while the function bit picks the alternate
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dir_cfg <= gpm_pkg::DIR_RESET;
      end else if (dir_wr) begin
         dir_cfg <= dir_wdata & PIN_MASK;
      end
   end

   // Value to drive on general outputs; kept while pin is an input
   // Not readable: the data view returns the sampled pin instead
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         drive_val <= gpm_pkg::DRIVE_RESET;
      end else if (data_wr) begin
         drive_val <= data_wdata & PIN_MASK;
      end
   end

   // Sampled pin levels, all modes, refreshed every interval
   // Limitation: a pulse shorter than one interval may be missed
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         level <= gpm_pkg::LEVEL_RESET;
      end else if (sample_tick) begin
         level <= pin_sync & PIN_MASK;
      end
   end

   // Registered pin values; the board sees them as asynchronous
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_out <= gpm_pkg::DRIVE_RESET;
      end else begin
         pin_out <= next_pin_out;
      end
   end

   // Registered enables; outputs stay released until configured
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_oe <= gpm_pkg::DIR_RESET;
      end else begin
         pin_oe <= next_pin_oe;
      end
   end

   // Alternate input towards on-chip logic
   // Registered so it leaves a flop, three edges after the pin moves
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         expander_interrupt_in_n <= gpm_pkg::ALT_INACTIVE;
      end else begin
         expander_interrupt_in_n <= next_exp_int_n;
      end
   end

   // Function read-back, one edge behind the live register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_function_select <= gpm_pkg::FUNC_RESET;
      end else begin
         pin_function_select <= func_sel;
      end
   end

   // Direction read-back, same lag as the enables it explains
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_direction_config <= gpm_pkg::DIR_RESET;
      end else begin
         pin_direction_config <= dir_cfg;
      end
   end

   // Level read-back, every pin in every mode
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_data_value <= gpm_pkg::LEVEL_RESET;
      end else begin
         pin_data_value <= level;
      end
   end

   // Unused: gp_in_mode documents the third mode; inputs need no drive
   // Kept so the three modes of each pin read side by side
   wire logic unused_in_mode = ^gp_in_mode;

endmodule // gpm_port

/* File: verif/gpm_port_monitor.sv */
`timescale 1ns/100ps

// Port-level timing checks, attached to the pin port
module gpm_port_monitor #(
   parameter int unsigned PIN_W = 10,
   parameter logic [9:0] PIN_MASK = 10'h38f
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic func_wr,
   input wire logic [9:0] func_wdata,
   input wire logic data_wr,
   input wire logic [9:0] data_wdata,
   input wire logic [9:0] pin_function_select,
   input wire logic [9:0] pin_direction_config,
   input wire logic [9:0] pin_data_value,
   input wire logic downstream_port_two_reset_out_n,
   input wire logic expander_interrupt_in_n,
   input wire logic [9:0] pin_in,
   input wire logic [9:0] pin_out,
   input wire logic [9:0] pin_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Short view; read-back lags the live select by one edge
   wire [9:0] fs = pin_function_select;
   sequence s_write(w);
      w ##1 !w;
   endsequence
   sequence s_steady;
      $stable(pin_in) [*8];
   endsequence
   AST_FUNC_RB: assert property (s_write(func_wr) |->
      ##1 fs == ($past(func_wdata, 2) & PIN_MASK)) else $error("bad select");
   AST_RESET: assert property ($rose(arst_n) |->
      pin_oe == 10'h000 && fs == 10'h000 && expander_interrupt_in_n)
      else $error("not idle after reset");
   AST_GPIO_OE: assert property ((pin_oe & ~fs) ==
      (pin_direction_config & ~fs & PIN_MASK)) else $error("bad enable");
   AST_ALT_OE: assert property ((fs & 10'h381 & ~pin_oe) == 10'h000 &&
      !(fs[2] && pin_oe[2])) else $error("bad alternate enable");
   AST_PORT_RST: assert property (fs[0] && $past(fs[0]) |->
      pin_out[0] == $past(downstream_port_two_reset_out_n))
      else $error("port reset not passed");
   AST_EXP: assert property (fs[2] [*4] |->
      expander_interrupt_in_n == $past(pin_in[2], 3)) else $error("bad irq");
   AST_INACT: assert property (!fs[2] && !$past(fs[2]) |->
      expander_interrupt_in_n) else $error("irq not held inactive");
   AST_GPO: assert property (s_write(data_wr) |-> ##1
      ((pin_out ^ $past(data_wdata, 2)) & pin_oe & ~fs) == 10'h000)
      else $error("bad drive value");
   AST_RATE: assert property ($changed(pin_data_value) |=>
      $stable(pin_data_value) [*3]) else $error("sampled too often");
   AST_LEVEL: assert property (s_steady |->
      pin_data_value == (pin_in & PIN_MASK)) else $error("bad level");
endmodule // gpm_port_monitor

/* File: verif/gpm_board.sv */
`timescale 1ns/100ps

// Board side of the pins: chip drive, a test source, else pull-ups
module gpm_board (
   input wire logic [9:0] pin_out,
   input wire logic [9:0] pin_oe,
   input wire logic [9:0] ext_en,
   input wire logic [9:0] ext_val,
   output logic [9:0] pin_in
);
   // Levels are read with no clock at all, so any phase is seen
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~ext_en) |
      (~pin_oe & ext_en & ext_val);
endmodule // gpm_board

/* File: verif/gpm_port_tb.sv */
`timescale 1ns/100ps

// Self-checking bench for the pin port
module gpm_port_tb;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic func_wr = 1'b0, dir_wr = 1'b0, data_wr = 1'b0;
   logic [9:0] wdata = 10'h000, ext_en = 10'h000, ext_val = 10'h000;
   logic p2_n = 1'b1, p1_n = 1'b1, p3_n = 1'b1, ev_n = 1'b1;
   logic [9:0] fsel, dcfg, dval, pin_in, pin_out, pin_oe;
   logic exp_n;
   int n_errors = 0;
   int comparisons = 0;
   always #20 clk = ~clk;
   gpm_port gpm_port_inst (.clk(clk), .arst_n(arst_n), .func_wr(func_wr),
      .func_wdata(wdata), .dir_wr(dir_wr), .dir_wdata(wdata),
      .data_wr(data_wr), .data_wdata(wdata), .pin_function_select(fsel),
      .pin_direction_config(dcfg), .pin_data_value(dval),
      .downstream_port_two_reset_out_n(p2_n),
      .downstream_port_one_reset_out_n(p1_n),
      .downstream_port_three_reset_out_n(p3_n), .event_output_n(ev_n),
      .expander_interrupt_in_n(exp_n), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe));
   gpm_board gpm_board_inst (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
   task check(input logic [9:0] seen, input logic [9:0] want);
      comparisons++;
      if (seen !== want) begin
         n_errors++;
         $display("FAIL %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // One write; an idle edge follows so strobes never re-rise at once
   task wr(input int which, input logic [9:0] v);
      {func_wr, dir_wr, data_wr} = 3'b100 >> which;
      wdata = v;
      tick(1);
      {func_wr, dir_wr, data_wr} = 3'b000;
      tick(1);
   endtask
   task do_reset;
      arst_n = 1'b0;
      tick(6);
      arst_n = 1'b1;
      check(fsel | pin_oe, 10'h000);
      check({9'h000, exp_n}, 10'h001);
   endtask
   // Inputs follow the board; unbonded pull-ups must read zero
   task t_input;
      ext_en = 10'h38f;
      ext_val = 10'h285;
      tick(10);
      check(dval, 10'h285);
      ext_val = 10'h10a;
      tick(10);
      check(dval, 10'h10a);
   endtask
   // Board source released first so outputs never fight it
   task t_output;
      ext_en = 10'h000;
      wr(2, 10'h30a);
      wr(1, 10'h3ff);
      tick(1);
      check(pin_oe, 10'h38f);
      check(dcfg, 10'h38f);
      check(pin_out & pin_oe, 10'h30a);
      tick(8);
      check(dval, 10'h30a);
      // A new value while driving reaches the pins two edges on
      wr(2, 10'h18f);
      tick(1);
      check(pin_out, 10'h18f);
      tick(8);
      check(dval, 10'h18f);
   endtask
   // Alternates win whatever the direction bits hold
   task t_alt;
      {p2_n, p1_n, p3_n, ev_n} = 4'h0;
      ext_en = 10'h004;
      ext_val = 10'h000;
      wr(0, 10'h385);
      tick(8);
      check(fsel, 10'h385);
      check(pin_oe, 10'h38b);
      check(pin_out & 10'h381, 10'h000);
      check({9'h000, exp_n}, 10'h000);
      check(dval, 10'h00a);
      {p2_n, p1_n, p3_n, ev_n} = 4'ha;
      ext_val = 10'h004;
      tick(4);
      check(pin_out & 10'h381, 10'h201);
      check({9'h000, exp_n}, 10'h001);
      ext_val = 10'h000;
      tick(4);
      wr(0, 10'h000);
      tick(2);
      check({9'h000, exp_n}, 10'h001);
      check(pin_oe, 10'h38f);
   endtask
   task conclude;
      if (n_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      do_reset();
      t_input();
      t_output();
      t_alt();
      do_reset();
      conclude();
   end
endmodule // gpm_port_tb

bind gpm_port gpm_port_monitor #(.PIN_W(PIN_W), .PIN_MASK(PIN_MASK))
   gpm_port_monitor_inst (.clk(clk), .arst_n(arst_n), .func_wr(func_wr),
   .func_wdata(func_wdata), .data_wr(data_wr), .data_wdata(data_wdata),
   .pin_function_select(pin_function_select),
   .pin_direction_config(pin_direction_config),
   .pin_data_value(pin_data_value),
   .downstream_port_two_reset_out_n(downstream_port_two_reset_out_n),
   .expander_interrupt_in_n(expander_interrupt_in_n), .pin_in(pin_in),
   .pin_out(pin_out), .pin_oe(pin_oe));
